// ---- hdl/flrf_map.svh ----
/*
 fault log record formatter: offsets, field positions, reset values and counts.
 assumes inclusion by bare name from the package and the design modules.
*/
`ifndef FLRF_MAP_SVH
`define FLRF_MAP_SVH

// register offsets (byte addresses)
`define FLRF_ADDR_W      8
`define FLRF_REG_CTRL    8'h00
`define FLRF_REG_STATUS  8'h04
`define FLRF_REG_LOG     8'h08
`define FLRF_REG_TS_LO   8'h0C
`define FLRF_REG_TS_HI   8'h10

// control bits
`define FLRF_CTRL_STORE  0
`define FLRF_CTRL_RDRST  1
`define FLRF_CTRL_PINEVT 5
`define FLRF_PINEVT_RST  1'b0

// log geometry
`define FLRF_ENTRIES     4
`define FLRF_EVT_BITS    168
`define FLRF_SUB_BITS    64
`define FLRF_ENT_BITS    296
`define FLRF_LOG_BITS    1184
`define FLRF_LAST_BYTE   8'h93
`define FLRF_TS_BITS     45
`define FLRF_ENT_MAX     3'h4

// event field positions
`define FLRF_EVT_PAR_BIT 112
`define FLRF_EVT_CRC_BIT 105
`define FLRF_SUB_CRC_BIT 104
`define FLRF_TEMP_LSB    96
`define FLRF_CH1_LSB     92
`define FLRF_CH0_LSB     88
`define FLRF_PWARN_LSB   74
`define FLRF_UWARN_BIT   73
`define FLRF_PFAULT_LSB  55
`define FLRF_UFAULT_LSB  53
`define FLRF_TS_LSB      8
`define FLRF_ORD_LSB     3
`define FLRF_PAGE_LSB    1
`define FLRF_VALID_BIT   0

// subevent field positions
`define FLRF_SUB_CH1_LSB 57
`define FLRF_SUB_CH0_LSB 53

// encodings
`define FLRF_TEMP_OFS    8'h46
`define FLRF_PAGE_UNPAGED 2'h2
`define FLRF_ORD_NONE    5'h00
`define FLRF_ORD_PIN     5'h0C

`endif

// ---- hdl/flrf_pkg.sv ----
/*
 fault log record formatter: shared types.
 assumes flrf_map.svh is on the include path.
*/
`include "flrf_map.svh"

package flrf_pkg;

   // channel state codes
   typedef enum logic [3:0] {
      FLRF_CH_OFF       = 4'h0,
      FLRF_CH_RETRY     = 4'h1,
      FLRF_CH_ON_DELAY  = 4'h2,
      FLRF_CH_RAMP_UP   = 4'h3,
      FLRF_CH_WAIT_UV   = 4'h4,
      FLRF_CH_ON        = 4'h5,
      FLRF_CH_OFF_DELAY = 4'h6,
      FLRF_CH_RESET     = 4'h7,
      FLRF_CH_RAMP_DOWN = 4'h8
   } flrf_chan_e;

   // unpaged cause ordinals
   typedef enum logic [4:0] {
      FLRF_U_NONE     = 5'h00,
      FLRF_U_REF      = 5'h01,
      FLRF_U_TSD      = 5'h02,
      FLRF_U_OT_WARN  = 5'h05
   } flrf_uord_e;

   // paged cause ordinals: warnings, continue faults, fault-off
   typedef enum logic [4:0] {
      FLRF_P_NONE        = 5'h00,
      FLRF_P_SHORT_CYC   = 5'h02,
      FLRF_P_TON_OFF     = 5'h04,
      FLRF_P_IOUT_OC_OFF = 5'h05,
      FLRF_P_VOUT_UV_OFF = 5'h06,
      FLRF_P_VOUT_OV_OFF = 5'h07,
      FLRF_P_VIN_OV      = 5'h09,
      FLRF_P_PIN_LOW     = 5'h0C,
      FLRF_P_TON_CONT    = 5'h0D,
      FLRF_P_IOUT_OC_CNT = 5'h0E,
      FLRF_P_VOUT_UV_CNT = 5'h0F,
      FLRF_P_VOUT_OV_CNT = 5'h10,
      FLRF_P_INPUT_OFF_THRESHOLD     = 5'h11,
      FLRF_P_TOFF_WARN   = 5'h13,
      FLRF_P_IIN_OC_W    = 5'h14,
      FLRF_P_VIN_UV_W    = 5'h15,
      FLRF_P_IOUT_OC_W   = 5'h17,
      FLRF_P_VOUT_UV_W   = 5'h18,
      FLRF_P_VOUT_OV_W   = 5'h19
   } flrf_pord_e;

   // live conditions; per page fault bits 8..0 and warning bits 6..0
   typedef struct packed {
      logic [17:0] pfault;
      logic [13:0] pwarn;
      logic [1:0]  ufault;
      logic        uwarn;
      flrf_chan_e  ch1;
      flrf_chan_e  ch0;
      logic [7:0]  temp;
   } flrf_cond_s;

   // one recording request
   typedef struct packed {
      logic       vld;
      logic [4:0] ord;
      logic [1:0] page;
   } flrf_cause_s;

endpackage : flrf_pkg

// ---- hdl/flrf_sync3.sv ----
/*
 three-stage pin synchroniser with agreement filter.
 assumes inputs asynchronous to ref_clk; output changes once stages two and three agree.
*/
`timescale 1ns/1ps

module flrf_sync3 import flrf_pkg::*; #(
   parameter int           W   = 2,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout_q
);

   genvar i;
   // one chain per bit
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         wire  agree = (s2_q == s3_q);
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               s1_q      <= RST[i];
               s2_q      <= RST[i];
               s3_q      <= RST[i];
               dout_q[i] <= RST[i];
            end else if (ce) begin
               s1_q <= din[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (agree) begin
                  dout_q[i] <= s3_q;
               end
            end
         end
      end
   endgenerate

endmodule : flrf_sync3

// ---- hdl/flrf_formatter.sv ----
/*
 fault log record formatter: builds event and subevent records from live
 conditions, keeps two volatile subevents, commits four-entry log, byte readout.
 assumes a plain register port master on ref_clk and same-clock cause inputs;
 shared timing clock and fault pin arrive asynchronously on pins.
*/
`timescale 1ns/1ps
`include "flrf_map.svh"

module flrf_formatter import flrf_pkg::*; (
   input  wire logic                     ref_clk,
   input  wire logic                     rstn,
   input  wire logic                     ce,
   input  wire logic [`FLRF_ADDR_W-1:0]  addr,
   input  wire logic [31:0]              wdata,
   input  wire logic                     wr_stb,
   input  wire logic                     rd_stb,
   output logic      [31:0]              rd_data_q,
   input  wire logic                     shared_timing_clock,
   input  wire logic                     fault_pin_n,
   input  wire logic [1:0]               pin_page,
   input  wire flrf_cond_s               cond,
   input  wire flrf_cause_s              fault_off,
   input  wire flrf_cause_s              sub_evt,
   input  wire logic                     evt_crc_err,
   input  wire logic                     sub_crc_err,
   output logic                          log_commit_q
);

   logic [1:0]               pins_f;
   logic                     stc_prev_q;
   logic                     pin_prev_q;
   logic [`FLRF_TS_BITS-1:0] ts_q;
   logic                     pinevt_q;
   logic [`FLRF_SUB_BITS-1:0] sub_q [0:1];
   logic [`FLRF_ENT_BITS-1:0] log_q [0:`FLRF_ENTRIES-1];
   logic [7:0]               rd_ptr_q;
   logic [2:0]               ent_cnt_q;

   // pin synchronisers: shared timing clock idles low, fault pin idles high
   flrf_sync3 #(
      .W   (2),
      .RST (2'b01)
   ) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .din     ({shared_timing_clock, fault_pin_n}),
      .dout_q  (pins_f)
   );

   // edge detection on filtered pins
   wire stc_f    = pins_f[1];
   wire pin_f    = pins_f[0];
   wire ts_tick  = stc_f & ~stc_prev_q;
   wire pin_fall = pin_prev_q & ~pin_f;

   // register decode
   wire wr_ctrl   = wr_stb & (addr == `FLRF_REG_CTRL);
   wire rd_log    = rd_stb & (addr == `FLRF_REG_LOG);
   wire store_req = wr_ctrl & wdata[`FLRF_CTRL_STORE];
   wire rd_rst    = wr_ctrl & wdata[`FLRF_CTRL_RDRST];

   // fault pin routed as event or subevent
   wire pin_as_evt = pin_fall & pinevt_q;
   wire pin_as_sub = pin_fall & ~pinevt_q;

   // cause selection: fault-off, then pin, then forced store
   wire flrf_cause_s pin_cause   = '{vld: 1'b1, ord: `FLRF_ORD_PIN, page: pin_page};
   wire flrf_cause_s store_cause = '{vld: 1'b1, ord: `FLRF_ORD_NONE,
                                     page: `FLRF_PAGE_UNPAGED};
   wire flrf_cause_s evt_cause = fault_off.vld ? fault_off :
                                 pin_as_evt    ? pin_cause :
                                 store_req     ? store_cause : '0;
   wire flrf_cause_s sub_cause = sub_evt.vld ? sub_evt :
                                 pin_as_sub  ? pin_cause : '0;
   wire commit     = evt_cause.vld;
   wire commit_en  = commit & ce;

   // event record from conditions present now
   wire [7:0]   temp_enc = 8'(cond.temp + `FLRF_TEMP_OFS);
   wire [111:0] evt_low  = {6'h00,
                            evt_crc_err, sub_crc_err,
                            temp_enc,
                            cond.ch1, cond.ch0,
                            cond.pwarn,
                            cond.uwarn,
                            cond.pfault,
                            cond.ufault,
                            ts_q,
                            evt_cause.ord, evt_cause.page,
                            1'b1};
   wire [`FLRF_EVT_BITS-1:0] evt_rec = {55'h0, ^evt_low, evt_low};

   // subevent record
   wire [`FLRF_SUB_BITS-1:0] sub_rec = {3'h0, cond.ch1, cond.ch0, ts_q,
                                        sub_cause.ord, sub_cause.page, 1'b1};

   // new entry: older subevent on top, newer next, event lowest
   wire [`FLRF_ENT_BITS-1:0] new_ent = {sub_q[1], sub_q[0], evt_rec};

   // flattened byte stream, entry 0 at byte 0
   wire [`FLRF_LOG_BITS-1:0] stream;
   genvar e;
   generate
      for (e = 0; e < `FLRF_ENTRIES; e++) begin : g_ent
         assign stream[e*`FLRF_ENT_BITS +: `FLRF_ENT_BITS] = log_q[e];
         // entry shift on commit
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               log_q[e] <= '0;
            end else if (commit_en) begin
               log_q[e] <= (e == 0) ? new_ent : log_q[(e == 0) ? 0 : e - 1];
            end
         end
      end
   endgenerate

   wire [10:0] byte_base = {rd_ptr_q, 3'b000};
   wire [7:0]  log_byte  = stream[byte_base +: 8];

   // read selection
   wire        sel_ctrl   = (addr == `FLRF_REG_CTRL);
   wire        sel_status = (addr == `FLRF_REG_STATUS);
   wire        sel_log    = (addr == `FLRF_REG_LOG);
   wire        sel_ts_lo  = (addr == `FLRF_REG_TS_LO);
   wire        sel_ts_hi  = (addr == `FLRF_REG_TS_HI);
   wire [31:0] ctrl_w     = {26'h0, pinevt_q, 5'h00};
   wire [31:0] status_w   = {16'h0, rd_ptr_q, 3'h0, sub_q[1][0], sub_q[0][0], ent_cnt_q};
   wire [31:0] log_w      = {24'h0, log_byte};
   wire [31:0] ts_hi_w    = {19'h0, ts_q[44:32]};
   wire [31:0] rd_mux =
      sel_ctrl   ? ctrl_w :
      sel_status ? status_w :
      sel_log    ? log_w :
      sel_ts_lo  ? ts_q[31:0] :
      sel_ts_hi  ? ts_hi_w : 32'h0;

   // pin edge history and timestamp
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stc_prev_q <= 1'b0;
         pin_prev_q <= 1'b1;
         ts_q       <= '0;
      end else if (ce) begin
         stc_prev_q <= stc_f;
         pin_prev_q <= pin_f;
         if (ts_tick) begin
            ts_q <= 45'(ts_q + 45'h1);
         end
      end
   end

   // control register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pinevt_q <= `FLRF_PINEVT_RST;
      end else if (ce && wr_ctrl) begin
         pinevt_q <= wdata[`FLRF_CTRL_PINEVT];
      end
   end

   // volatile subevent pair, emptied by each commit except for a subevent taken in the same cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sub_q[0] <= '0;
         sub_q[1] <= '0;
      end else if (ce) begin
         if (commit) begin
            sub_q[0] <= sub_cause.vld ? sub_rec : '0;
            sub_q[1] <= '0;
         end else if (sub_cause.vld) begin
            sub_q[0] <= sub_rec;
            sub_q[1] <= sub_q[0];
         end
      end
   end

   // read pointer, entry count, read data, commit strobe
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_ptr_q     <= 8'h00;
         ent_cnt_q    <= 3'h0;
         rd_data_q    <= 32'h0;
         log_commit_q <= 1'b0;
      end else if (ce) begin
         if (rd_rst) begin
            rd_ptr_q <= 8'h00;
         end else if (rd_log) begin
            rd_ptr_q <= (rd_ptr_q == `FLRF_LAST_BYTE) ? 8'h00 : 8'(rd_ptr_q + 8'h01);
         end
         if (commit && ent_cnt_q != `FLRF_ENT_MAX) begin
            ent_cnt_q <= 3'(ent_cnt_q + 3'h1);
         end
         rd_data_q    <= rd_stb ? rd_mux : 32'h0;
         log_commit_q <= commit;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   log_shift_a: assert property (commit_en |=> log_q[1] == $past(log_q[0])
         && log_q[3] == $past(log_q[2]))
      else $error("log entries did not shift on commit");
   evt_valid_a: assert property (commit_en |=> log_q[0][`FLRF_VALID_BIT])
      else $error("committed event not marked valid");
   temp_enc_a: assert property (commit_en |=>
         log_q[0][`FLRF_TEMP_LSB +: 8] == 8'($past(cond.temp) + `FLRF_TEMP_OFS))
      else $error("temperature byte not offset by seventy");
   chan_state_a: assert property (commit_en |=>
         log_q[0][`FLRF_CH1_LSB +: 4] == $past(cond.ch1)
         && log_q[0][`FLRF_CH0_LSB +: 4] == $past(cond.ch0))
      else $error("channel states misplaced in event");
   live_cond_a: assert property (commit_en |=>
         log_q[0][`FLRF_PFAULT_LSB +: 18] == $past(cond.pfault)
         && log_q[0][`FLRF_PWARN_LSB +: 14] == $past(cond.pwarn)
         && log_q[0][`FLRF_UWARN_BIT] == $past(cond.uwarn))
      else $error("event fields differ from live conditions");
   crc_bits_a: assert property (commit_en |=>
         log_q[0][`FLRF_EVT_CRC_BIT] == $past(evt_crc_err)
         && log_q[0][`FLRF_SUB_CRC_BIT] == $past(sub_crc_err))
      else $error("crc result bits wrong");
   forced_ord_a: assert property (commit_en && !fault_off.vld && !pin_as_evt
         |=> log_q[0][7:0] == {`FLRF_ORD_NONE, `FLRF_PAGE_UNPAGED, 1'b1})
      else $error("forced store ordinal or page wrong");
   pin_evt_a: assert property (ce && pin_as_evt && !fault_off.vld
         |=> log_q[0][`FLRF_ORD_LSB +: 5] == `FLRF_ORD_PIN
         && log_q[0][`FLRF_PAGE_LSB +: 2] == $past(pin_page) && log_commit_q)
      else $error("fault pin not recorded as event");
   sub_commit_a: assert property (commit_en && !sub_cause.vld
         |=> sub_q[0] == '0 && sub_q[1] == '0
         && log_q[0][`FLRF_EVT_BITS +: 64] == $past(sub_q[0]))
      else $error("subevents not committed with event");
   rsvd_zero_a: assert property (log_q[0][167:113] == '0
         && log_q[0][111:106] == '0)
      else $error("reserved event bits not zero");
   ts_count_a: assert property (ce && ts_tick |=> ts_q == 45'($past(ts_q) + 45'h1))
      else $error("timestamp missed a shared clock pulse");
   rd_byte_a: assert property (ce && rd_log |=> rd_data_q == {24'h0, $past(log_byte)})
      else $error("log byte not returned one cycle after read");

   // event field placement
   ufault_pos_a: assert property (commit_en |=>
         log_q[0][`FLRF_UFAULT_LSB +: 2] == $past(cond.ufault))
      else $error("unpaged fault bits misplaced");
   evt_ord_a: assert property (ce && fault_off.vld |=>
         log_q[0][7:1] == {$past(fault_off.ord), $past(fault_off.page)})
      else $error("event ordinal or page wrong");
   evt_ts_a: assert property (commit_en |=>
         log_q[0][`FLRF_TS_LSB +: 45] == $past(ts_q))
      else $error("event timestamp wrong");
   parity_a: assert property (log_q[0][`FLRF_EVT_PAR_BIT] == ^log_q[0][111:0])
      else $error("event parity bit wrong");

   // subevent pair, commit strobe and idle log
   sub_layout_a: assert property (ce && sub_cause.vld && !commit |=>
         sub_q[0] == {3'h0, $past(cond.ch1), $past(cond.ch0), $past(ts_q),
                      $past(sub_cause.ord), $past(sub_cause.page), 1'b1}
         && sub_q[1] == $past(sub_q[0]))
      else $error("subevent record layout wrong");
   sub_carry_a: assert property (commit_en && sub_evt.vld |=>
         sub_q[0][7:0] == {$past(sub_evt.ord), $past(sub_evt.page), 1'b1}
         && sub_q[1] == '0)
      else $error("subevent in commit cycle not kept");
   sub_idle_a: assert property (ce && !commit && !sub_cause.vld |=>
         $stable(sub_q[0]) && $stable(sub_q[1]))
      else $error("subevents changed with no cause");
   pin_sub_a: assert property (ce && pin_as_sub && !sub_evt.vld |=>
         sub_q[0][7:0] == {`FLRF_ORD_PIN, $past(pin_page), 1'b1})
      else $error("fault pin not recorded as subevent");
   commit_pulse_a: assert property (ce |=> log_commit_q == $past(commit))
      else $error("commit strobe wrong");
   log_idle_a: assert property (!commit_en |=> $stable(log_q[0]) && $stable(log_q[3]))
      else $error("log changed with no commit");

   // entry count and control setting
   ent_cnt_a: assert property (commit_en && ent_cnt_q != `FLRF_ENT_MAX |=>
         ent_cnt_q == 3'($past(ent_cnt_q) + 3'h1))
      else $error("entry count did not advance");
   ctrl_rb_a: assert property (ce && wr_ctrl |=>
         pinevt_q == $past(wdata[`FLRF_CTRL_PINEVT]))
      else $error("pin event setting not stored");

   // read port
   rd_idle_a: assert property (ce && !rd_stb |=> rd_data_q == 32'h0)
      else $error("read data not cleared outside read answer");
   ptr_wrap_a: assert property (ce && rd_log && !rd_rst
         && rd_ptr_q == `FLRF_LAST_BYTE |=> rd_ptr_q == 8'h00)
      else $error("log pointer did not wrap after last byte");
   rewind_a: assert property (ce && rd_rst |=> rd_ptr_q == 8'h00)
      else $error("log pointer not rewound");
   status_rd_a: assert property (ce && rd_stb && sel_status |=>
         rd_data_q[2:0] == $past(ent_cnt_q))
      else $error("entry count read wrong");
   ctrl_rd_a: assert property (ce && rd_stb && sel_ctrl |=>
         rd_data_q == {26'h0, $past(pinevt_q), 5'h00})
      else $error("control read back wrong");

   // timestamp
   ts_hold_a: assert property (!ts_tick |=> $stable(ts_q))
      else $error("timestamp moved with no shared clock pulse");
   ts_rd_a: assert property (ce && rd_stb && sel_ts_lo |=>
         rd_data_q == $past(ts_q[31:0]))
      else $error("timestamp low word read wrong");

   // clock enable low freezes state
   freeze_a: assert property (!ce |=> $stable(ts_q) && $stable(rd_ptr_q)
         && $stable(log_q[0]) && $stable(rd_data_q))
      else $error("state moved while clock enable low");

   // main scenarios
   commit_c: cover property (commit_en ##[1:20] commit_en);
   pin_sub_c: cover property (ce && pin_as_sub);
   store_c: cover property (ce && store_req && !fault_off.vld);
   wrap_c: cover property (ce && rd_log && rd_ptr_q == `FLRF_LAST_BYTE);
   pin_evt_c: cover property (ce && pin_as_evt);

endmodule : flrf_formatter

// ---- verification/flrf_host_model.sv ----
/*
 host model: register port master that reads the record stream.
 assumes read data stand only in the cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "flrf_map.svh"

module flrf_host_model import flrf_pkg::*; (
   input  wire logic                    ref_clk,
   output logic      [`FLRF_ADDR_W-1:0] addr,
   output logic      [31:0]             wdata,
   output logic                         wr_stb,
   output logic                         rd_stb,
   input  wire logic [31:0]             rd_data_q
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // one write cycle; idle lines then carry inverted junk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      addr   <= ~a;
      wdata  <= ~d;
   endtask : wr

   // one read cycle; data taken once the answer edge has landed
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      addr   <= ~a;
      #1 d = rd_data_q;
   endtask : rd
endmodule : flrf_host_model

// ---- verification/tb.sv ----
/*
 self-checking bench for the fault log record formatter.
 assumes flrf_pkg, flrf_map.svh and the host model are compiled first.
*/
`timescale 1ns/1ps
`include "flrf_map.svh"

module tb import flrf_pkg::*;;
   logic                      ref_clk;
   logic                      rstn;
   logic                      ce;
   logic [7:0]                addr;
   logic [31:0]               wdata;
   logic                      wr_stb;
   logic                      rd_stb;
   logic [31:0]               rd_data_q;
   logic                      shared_timing_clock;
   logic                      fault_pin_n;
   logic [1:0]                pin_page;
   flrf_cond_s                cond;
   flrf_cause_s               fault_off;
   flrf_cause_s               sub_evt;
   logic                      evt_crc_err;
   logic                      sub_crc_err;
   logic                      log_commit_q;
   logic [`FLRF_LOG_BITS-1:0] exp_log;
   logic [63:0]               sub_q[$];
   logic [44:0]               ts;
   logic                      ctrl5;
   int                        seed = 65;
   int                        error_cnt = 0;
   int                        compares = 0;
   int                        commits = 0;
   int                        exp_commits = 0;

   // cause codes; first sub and first two fault-offs are unpaged
   localparam logic [4:0] sub_ords [12] = '{5'h05, 5'h19, 5'h18, 5'h17, 5'h15, 5'h14,
                                            5'h13, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D};
   localparam logic [4:0] off_ords [9]  = '{5'h01, 5'h02, 5'h0C, 5'h09, 5'h07, 5'h06,
                                            5'h05, 5'h04, 5'h02};

   flrf_formatter dut_u (
      .ref_clk             (ref_clk),
      .rstn                (rstn),
      .ce                  (ce),
      .addr                (addr),
      .wdata               (wdata),
      .wr_stb              (wr_stb),
      .rd_stb              (rd_stb),
      .rd_data_q           (rd_data_q),
      .shared_timing_clock (shared_timing_clock),
      .fault_pin_n         (fault_pin_n),
      .pin_page            (pin_page),
      .cond                (cond),
      .fault_off           (fault_off),
      .sub_evt             (sub_evt),
      .evt_crc_err         (evt_crc_err),
      .sub_crc_err         (sub_crc_err),
      .log_commit_q        (log_commit_q)
   );

   flrf_host_model host_u (
      .ref_clk   (ref_clk),
      .addr      (addr),
      .wdata     (wdata),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb),
      .rd_data_q (rd_data_q)
   );

   // clock and commit pulse counter
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (log_commit_q === 1'b1) commits++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up();
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   // random live conditions with legal channel codes
   function automatic flrf_cond_s rnd_cond();
      flrf_cond_s c;
      c = 66'({$random(seed), $random(seed), $random(seed)});
      c.ch1 = flrf_chan_e'(4'(unsigned'($random(seed)) % 9));
      c.ch0 = flrf_chan_e'(4'(unsigned'($random(seed)) % 9));
      return c;
   endfunction : rnd_cond

   function automatic logic [1:0] pg(input logic unpaged);
      return unpaged ? 2'h2 : {1'b0, 1'($random(seed))};
   endfunction : pg

   // reference model: subevents wait, an event commits them as entry 0
   task automatic rec(input logic sub, input flrf_cond_s c, input logic [4:0] o,
                      input logic [1:0] p);
      logic [167:0] e;
      if (sub) begin
         sub_q.push_back({3'h0, c.ch1, c.ch0, ts, o, p, 1'b1});
         if (sub_q.size() > 2) void'(sub_q.pop_front());
      end else begin
         e = {62'h0, evt_crc_err, sub_crc_err, c.temp + 8'h46, c.ch1, c.ch0, c.pwarn,
              c.uwarn, c.pfault, c.ufault, ts, o, p, 1'b1};
         e[112] = ^e[111:0];
         exp_log = {exp_log[887:0], (sub_q.size() > 1) ? sub_q[0] : 64'h0,
                    (sub_q.size() > 0) ? sub_q[$] : 64'h0, e};
         sub_q.delete();
         exp_commits++;
      end
   endtask : rec

   // one cause pulse; conditions move on at the taking edge
   task automatic ev(input logic sub, input logic [4:0] o, input logic [1:0] p);
      flrf_cond_s c;
      logic [1:0] crc;
      c = rnd_cond();
      crc = 2'($random(seed));
      @(posedge ref_clk);
      cond        <= c;
      evt_crc_err <= crc[1];
      sub_crc_err <= crc[0];
      if (sub) sub_evt <= {1'b1, o, p};
      else fault_off <= {1'b1, o, p};
      @(posedge ref_clk);
      sub_evt.vld   <= 1'b0;
      fault_off.vld <= 1'b0;
      cond          <= rnd_cond();
      rec(sub, c, o, p);
   endtask : ev

   task automatic tick(input int n);
      repeat (n) begin
         repeat (6) @(posedge ref_clk);
         shared_timing_clock <= 1'b1;
         repeat (6) @(posedge ref_clk);
         shared_timing_clock <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      ts += 45'(n);
   endtask : tick

   task automatic setcfg(input logic v);
      ctrl5 = v;
      host_u.wr(`FLRF_REG_CTRL, {26'h0, v, 5'h00});
   endtask : setcfg

   task automatic pin(input logic [1:0] p);
      pin_page    <= p;
      fault_pin_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      fault_pin_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rec(!ctrl5, cond, 5'h0C, p);
   endtask : pin

   // rewind, read every byte plus one wrap, then status and timestamp
   task automatic read_log();
      logic [31:0] d;
      host_u.wr(`FLRF_REG_CTRL, {26'h0, ctrl5, 5'h02});
      for (int i = 0; i <= 148; i++) begin
         host_u.rd(`FLRF_REG_LOG, d);
         chk(d, {24'h0, exp_log[8*(i%148) +: 8]});
      end
      host_u.rd(`FLRF_REG_STATUS, d);
      chk(d, {16'h0, 8'h01, 5'h0, (exp_commits > 4) ? 3'h4 : 3'(exp_commits)});
      host_u.rd(`FLRF_REG_TS_HI, d);
      chk(d, {19'h0, ts[44:32]});
      host_u.rd(`FLRF_REG_TS_LO, d);
      chk(d, ts[31:0]);
      host_u.rd(8'h14, d);
      chk(d, 32'h0);
   endtask : read_log

   // main sequence
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      shared_timing_clock = 1'b0;
      fault_pin_n = 1'b1;
      pin_page = 2'h0;
      cond = '0;
      fault_off = '0;
      sub_evt = '0;
      evt_crc_err = 1'b0;
      sub_crc_err = 1'b0;
      exp_log = '0;
      ts = '0;
      ctrl5 = 1'b0;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      read_log();
      tick(3);
      ev(1'b1, 5'h19, 2'h0);
      ev(1'b1, 5'h05, 2'h2);
      ev(1'b0, 5'h07, 2'h0);
      read_log();
      tick(2);
      for (int i = 0; i < 12; i++) begin
         ev(1'b1, sub_ords[i], pg(i == 0));
         if (i % 2 == 1) ev(1'b0, off_ords[i/2], pg(i < 4));
      end
      for (int j = 6; j < 9; j++) ev(1'b0, off_ords[j], pg(1'b0));
      read_log();
      tick(4);
      setcfg(1'b0);
      pin(2'h0);
      pin(2'h1);
      setcfg(1'b1);
      pin(2'h1);
      tick(1);
      host_u.wr(`FLRF_REG_CTRL, {26'h0, ctrl5, 5'h01});
      rec(1'b0, cond, 5'h00, 2'h2);
      // clock enable low: a fault-off request must leave no trace
      @(posedge ref_clk);
      ce        <= 1'b0;
      fault_off <= {1'b1, 5'h07, 2'h0};
      @(posedge ref_clk);
      fault_off.vld <= 1'b0;
      ce            <= 1'b1;
      read_log();
      repeat (4) @(posedge ref_clk);
      chk(commits, exp_commits);
      wrap_up();
   end

   // watchdog
   initial begin
      #200_000;
      error_cnt++;
      wrap_up();
   end
endmodule : tb
